// [design/rotate_instruction_exec.sv]
// Purpose: executes the two rotate instructions of an 8-bit core
// Assumes: instruction word held stable for a whole four-phase cycle
// Notes: file memory is outside; this block drives its address and write port
// Functional notes
// - rotate left: bit7 to bit0, N,Z
// - rotate right through carry: C,N,Z update
// - dest bit 0 accumulator, 1 file
// - access bit 0 access bank, else pointer
// - access, extended set, f<=5Fh: indexed offset
// - one word, one cycle: four phases
`timescale 1ns/100ps
module rotate_instruction_exec (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_pointer_reg,
    input wire logic [11:0] indexed_addr,
    input wire logic [7:0] file_rdata,
    output logic [11:0] file_addr,
    output logic file_rd,
    output logic file_we,
    output logic [7:0] file_wdata,
    output logic indexed_mode,
    output logic [7:0] acc_reg,
    output logic [4:0] status_reg,
    output logic [1:0] phase,
    output logic busy
);
    // ****************************************
    // decode
    // ****************************************
    rotate_exec_pkg::phase_e phase_reg;
    logic [5:0] opc;
    logic rotate_left_no_carry_op;
    logic rotate_right_thru_carry_op;
    logic is_rot;
    logic dest_file;
    logic use_access;
    logic [7:0] f_lit;
    logic [7:0] operand_reg;
    logic [7:0] result_reg;
    logic carry_out_reg;
    logic active_reg;
    logic left_reg;
    logic [11:0] addr_next;
    logic idx_next;
    logic [7:0] rot_left;
    logic [7:0] rot_right;
    logic carry_in;

    assign opc = instr_word[rotate_exec_pkg::OPC_HI:rotate_exec_pkg::OPC_LO];
    assign rotate_left_no_carry_op = opc == rotate_exec_pkg::OPC_ROT_LEFT_NC;
    assign rotate_right_thru_carry_op = opc == rotate_exec_pkg::OPC_ROT_RIGHT_C;
    assign is_rot = instr_valid && (rotate_left_no_carry_op || rotate_right_thru_carry_op);
    assign dest_file = instr_word[rotate_exec_pkg::DEST_BIT];
    assign use_access = !instr_word[rotate_exec_pkg::ACCESS_BIT];
    assign f_lit = instr_word[7:0];

    // ****************************************
    // address selection
    // ****************************************
    always_comb begin
        idx_next = use_access && ext_set_en
            && (f_lit <= rotate_exec_pkg::INDEXED_LIMIT);
        if (idx_next) begin
            addr_next = indexed_addr;
        end else if (use_access) begin
            addr_next = {(f_lit < rotate_exec_pkg::ACCESS_SPLIT) ?
                rotate_exec_pkg::ACCESS_LOW_BANK : rotate_exec_pkg::ACCESS_HIGH_BANK,
                f_lit};
        end else begin
            addr_next = {bank_pointer_reg, f_lit};
        end
    end

    // ****************************************
    // phase sequencer
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            phase_reg <= rotate_exec_pkg::PH_DECODE;
        end else if (clk_en) begin
            unique case (phase_reg)
                rotate_exec_pkg::PH_DECODE: phase_reg <= rotate_exec_pkg::PH_READ;
                rotate_exec_pkg::PH_READ: phase_reg <= rotate_exec_pkg::PH_PROCESS;
                rotate_exec_pkg::PH_PROCESS: phase_reg <= rotate_exec_pkg::PH_WRITE;
                rotate_exec_pkg::PH_WRITE: phase_reg <= rotate_exec_pkg::PH_DECODE;
            endcase
        end
    end

    // ****************************************
    // decode capture
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            active_reg <= 1'b0;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_DECODE) begin
            active_reg <= is_rot;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            left_reg <= 1'b0;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_DECODE) begin
            left_reg <= rotate_left_no_carry_op;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            file_addr <= 12'h000;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_DECODE) begin
            file_addr <= addr_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            indexed_mode <= 1'b0;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_DECODE) begin
            indexed_mode <= is_rot && idx_next;
        end
    end

    // ****************************************
    // read and process
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            operand_reg <= 8'h00;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_READ && active_reg) begin
            operand_reg <= file_rdata;
        end
    end

    // ****************************************
    // per-bit rotate networks
    // ****************************************
    assign carry_in = status_reg[rotate_exec_pkg::FLAG_C];

    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 8; bit_idx++) begin : g_rot
            assign rot_left[bit_idx] = operand_reg[(bit_idx + 7) % 8];
            if (bit_idx == 7) begin : g_top
                assign rot_right[bit_idx] = carry_in;
            end else begin : g_low
                assign rot_right[bit_idx] = operand_reg[bit_idx + 1];
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (srst) begin
            result_reg <= 8'h00;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_PROCESS && active_reg) begin
            if (left_reg) begin
                result_reg <= rot_left;
            end else begin
                result_reg <= rot_right;
            end
        end
    end

    // left rotate keeps carry as it was
    always_ff @(posedge core_clk) begin
        if (srst) begin
            carry_out_reg <= 1'b0;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_PROCESS && active_reg) begin
            if (left_reg) begin
                carry_out_reg <= carry_in;
            end else begin
                carry_out_reg <= operand_reg[0];
            end
        end
    end

    // ****************************************
    // write back and flags
    // ****************************************
    logic dest_file_reg;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dest_file_reg <= 1'b1;
        end else if (clk_en && phase_reg == rotate_exec_pkg::PH_DECODE) begin
            dest_file_reg <= dest_file;
        end
    end

    logic write_phase;
    assign write_phase = clk_en && phase_reg == rotate_exec_pkg::PH_WRITE && active_reg;
    assign file_rd = phase_reg == rotate_exec_pkg::PH_READ && active_reg;
    assign file_we = phase_reg == rotate_exec_pkg::PH_WRITE
        && active_reg && dest_file_reg;
    assign file_wdata = result_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            acc_reg <= rotate_exec_pkg::ACC_RESET;
        end else if (write_phase && !dest_file_reg) begin
            acc_reg <= result_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_reg <= rotate_exec_pkg::STATUS_RESET;
        end else if (write_phase) begin
            status_reg[rotate_exec_pkg::FLAG_N] <= result_reg[7];
            status_reg[rotate_exec_pkg::FLAG_Z] <= result_reg == 8'h00;
            status_reg[rotate_exec_pkg::FLAG_C] <= carry_out_reg;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign phase = phase_reg;
    assign busy = active_reg;
endmodule

// [include/rotate_exec_pkg.sv]
// Purpose: constants for the rotate instruction execution block
// Assumes: 16-bit program words, 8-bit data, four phases per instruction cycle
// Notes: opcode fields sit in the top bits of the instruction word
package rotate_exec_pkg;
    // ****************************************
    // opcode recognition
    // ****************************************
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 10;
    localparam logic [5:0] OPC_ROT_LEFT_NC = 6'h11;
    localparam logic [5:0] OPC_ROT_RIGHT_C = 6'h0C;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    // ****************************************
    // addressing
    // ****************************************
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    // ****************************************
    // status bits and reset values
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_e;
endpackage

// [sim/rotate_exec_monitor.sv]
// Purpose: checks rotate timing and results
// Assumes: instruction held for a whole cycle
// Notes: bound to the top module
`timescale 1ns/100ps
module rotate_exec_monitor (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_pointer_reg,
    input wire logic [11:0] indexed_addr,
    input wire logic [7:0] file_rdata,
    input wire logic [11:0] file_addr,
    input wire logic file_rd,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic indexed_mode,
    input wire logic [7:0] acc_reg,
    input wire logic [4:0] status_reg,
    input wire logic [1:0] phase,
    input wire logic busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    logic [7:0] rd_q;
    wire lft = instr_word[15:10] == rotate_exec_pkg::OPC_ROT_LEFT_NC;
    wire rgt = instr_word[15:10] == rotate_exec_pkg::OPC_ROT_RIGHT_C;
    wire dec = clk_en && phase == 2'h0;
    wire take = dec && instr_valid && (lft || rgt);
    wire wr = busy && phase == 2'h3;
    always_ff @(posedge core_clk) if (clk_en && phase == 2'h1) rd_q <= file_rdata;
    sequence s_walk;
        file_rd && busy ##2 file_we == instr_word[9];
    endsequence
    a_walk_phases: assert property (take |=> s_walk)
        else $error("phase walk wrong");
    a_refused_idle: assert property (dec && !take |=> !busy && !file_rd ##2 !file_we)
        else $error("refused op acted");
    a_left_result: assert property (wr && lft |-> file_wdata == {rd_q[6:0], rd_q[7]})
        else $error("left result wrong");
    a_right_result: assert property (wr && rgt
        |-> file_wdata == {status_reg[0], rd_q[7:1]})
        else $error("right result wrong");
    a_left_keeps_c: assert property (wr && lft |=> $stable(status_reg[0]))
        else $error("left rotate changed carry");
    a_carry_out: assert property (wr && rgt |=> status_reg[0] == rd_q[0])
        else $error("carry wrong");
    a_nz_flags: assert property (wr |=> status_reg[4] == ($past(file_wdata) >= 8'h80)
        && status_reg[2] == ($past(file_wdata) == 8'h00))
        else $error("n z flags wrong");
    a_acc_dest: assert property (wr && !instr_word[9] |=> acc_reg == $past(file_wdata))
        else $error("acc not written");
    a_indexed_addr: assert property (take && !instr_word[8] && ext_set_en
        && instr_word[7:0] <= 8'h5F |=> indexed_mode && file_addr == $past(indexed_addr))
        else $error("indexed address wrong");
    a_bank_select: assert property (take && instr_word[8]
        |=> file_addr == {$past(bank_pointer_reg), instr_word[7:0]})
        else $error("bank address wrong");
    a_access_bank: assert property (take && !instr_word[8]
        && !(ext_set_en && instr_word[7:0] <= 8'h5F)
        |=> !indexed_mode && file_addr == {{4{instr_word[7:0] >= 8'h60}}, instr_word[7:0]})
        else $error("access bank address wrong");
endmodule
bind rotate_instruction_exec rotate_exec_monitor i_mon (.*);

// [sim/rotate_instruction_exec_tb.sv]
// Purpose: directed bench for rotate execution
// Assumes: phase runs freely after reset
// Notes: acc and flags are checked one op later
`timescale 1ns/100ps
module rotate_instruction_exec_tb;
    logic core_clk = 0, srst = 1, clk_en = 1, instr_valid = 1, ext_set_en = 0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] bank_pointer_reg = 4'h3;
    logic [11:0] indexed_addr = 12'hABC, file_addr;
    logic [7:0] file_rdata = 8'h00, file_wdata, acc_reg, exp_acc = 8'h00;
    logic file_rd, file_we, indexed_mode, busy;
    logic [4:0] status_reg, exp_st = 5'h00;
    logic [1:0] phase;
    int mismatches = 0, checked = 0;
    rotate_instruction_exec i_dut (.*);
    always #10 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [11:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input logic [5:0] opc, input logic v, d, a, e, input logic [7:0] f, rd);
        logic ok, lft, ix;
        logic [7:0] res;
        logic [11:0] adr;
        @(posedge core_clk);
        instr_word <= {opc, d, a, f};
        instr_valid <= v;
        file_rdata <= rd;
        ext_set_en <= e;
        #1 chk("acc", acc_reg, exp_acc);
        chk("status", status_reg, exp_st);
        lft = opc == rotate_exec_pkg::OPC_ROT_LEFT_NC;
        ok = v && (lft || opc == rotate_exec_pkg::OPC_ROT_RIGHT_C);
        ix = !a && e && f <= 8'h5F;
        adr = ix ? indexed_addr : {a ? bank_pointer_reg : {4{f > 8'h5F}}, f};
        res = lft ? {rd[6:0], rd[7]} : {exp_st[0], rd[7:1]};
        @(posedge core_clk);
        #1 chk("busy", busy, ok);
        chk("read", file_rd, ok);
        chk("phase", phase, 2'h1);
        if (ok) chk("addr", file_addr, adr);
        if (ok) chk("indexed", indexed_mode, ix);
        repeat (2) @(posedge core_clk);
        #1 chk("we", file_we, ok && d);
        chk("phase", phase, 2'h3);
        if (ok) chk("wdata", file_wdata, res);
        if (ok) begin
            exp_st = {res[7], 1'b0, res == 8'h00, 1'b0, lft ? exp_st[0] : rd[0]};
            if (!d) exp_acc = res;
        end
        $display("test done opcode %h", opc);
    endtask
    task automatic freeze();
        @(posedge core_clk);
        clk_en <= 1'b0;
        instr_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
        #1 chk("held phase", phase, 2'h0);
        repeat (3) @(posedge core_clk);
        #1 chk("phase", phase, 2'h3);
        chk("busy", busy, 1'b0);
        chk("acc", acc_reg, exp_acc);
        $display("test done freeze");
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #5000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        op(rotate_exec_pkg::OPC_ROT_RIGHT_C, 1'b1, 1'b0, 1'b0, 1'b0, 8'h10, 8'hE6);
        op(rotate_exec_pkg::OPC_ROT_LEFT_NC, 1'b1, 1'b1, 1'b1, 1'b0, 8'h80, 8'hAB);
        op(rotate_exec_pkg::OPC_ROT_RIGHT_C, 1'b1, 1'b1, 1'b0, 1'b1, 8'h5F, 8'h01);
        op(rotate_exec_pkg::OPC_ROT_RIGHT_C, 1'b1, 1'b0, 1'b0, 1'b1, 8'h60, 8'h01);
        op(rotate_exec_pkg::OPC_ROT_LEFT_NC, 1'b1, 1'b0, 1'b0, 1'b0, 8'h05, 8'h00);
        freeze();
        op(rotate_exec_pkg::OPC_ROT_LEFT_NC, 1'b0, 1'b1, 1'b1, 1'b0, 8'h22, 8'hFF);
        op(6'h00, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'hFF);
        @(posedge core_clk);
        #1 chk("acc", acc_reg, exp_acc);
        chk("status", status_reg, exp_st);
        finish_test();
    end
endmodule
